/* design/iec_pkg.sv */
// Purpose: Shared constants and types of the interrupt entry control block
// Assumes: 50 MHz system clock, four clocks per instruction cycle
// Notes: Register offsets are byte addresses on the AXI4-Lite slave
package iec_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_PF1 = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_PF2 = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_PE1 = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_PE2 = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_WAKE = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_SEQ = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_ISTS = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_IMSK = 6'h20;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int GLB_EN_BIT = 7;
  localparam int GRP_EN_BIT = 6;
  localparam int TIM_EN_BIT = 5;
  localparam int EXT_EN_BIT = 4;
  localparam int CHG_EN_BIT = 3;
  localparam int TIM_FLAG_BIT = 2;
  localparam int EXT_FLAG_BIT = 1;
  localparam int CHG_FLAG_BIT = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PE1_RST = 8'h04;
  localparam logic [7:0] PE2_RST = 8'h00;
  localparam int WAKE_CTRL_BIT = 0;
  localparam int WAKE_P1_BIT = 1;
  localparam int WAKE_P2_BIT = 2;
  localparam int EV_W = 3;
  localparam int EV_ENTRY = 0;
  localparam int EV_RETURN = 1;
  localparam int EV_WAKE = 2;

  // ----------------------------------------
  // Core and bus constants
  // ----------------------------------------
  localparam int PC_W = 13;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_NS = 20;
  localparam int TCY_NS = 80;
  localparam int TCY_CLKS = (TCY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;

  typedef enum logic [2:0] {
    IEC_IDLE = 3'h0,
    IEC_FLUSH = 3'h1,
    IEC_PUSH = 3'h3,
    IEC_JUMP = 3'h2,
    IEC_WAKE = 3'h6
  } iec_seq_e;

endpackage : iec_pkg

/* design/iec_flag_if.sv */
// Purpose: Carries flag writes, events, enables and results between top and flag bank
// Assumes: One clock domain
// Notes: Owner modport belongs to the flag bank
interface iec_flag_if;
  logic [7:0] wdata;
  logic wr_ctrl;
  logic wr_pf1;
  logic wr_pf2;
  logic ev_tmr0;
  logic ev_int;
  logic [7:0] ev_pf1;
  logic [7:0] ev_pf2;
  logic ioc_any;
  logic [7:0] ctrl_en;
  logic [7:0] pe1;
  logic [7:0] pe2;
  logic [2:0] wake_en;
  logic sleeping;
  logic [2:0] ctrl_flags;
  logic [7:0] pf1;
  logic [7:0] pf2;
  logic pending;
  logic wake_req;

  modport owner (input wdata, wr_ctrl, wr_pf1, wr_pf2, ev_tmr0, ev_int, ev_pf1, ev_pf2, ioc_any,
    ctrl_en, pe1, pe2, wake_en, sleeping, output ctrl_flags, pf1, pf2, pending, wake_req);
  modport user (output wdata, wr_ctrl, wr_pf1, wr_pf2, ev_tmr0, ev_int, ev_pf1, ev_pf2, ioc_any,
    ctrl_en, pe1, pe2, wake_en, sleeping, input ctrl_flags, pf1, pf2, pending, wake_req);
endinterface : iec_flag_if

/* design/iec_flags.sv */
// Purpose: Source flag bank with enable gating and wake detection
// Assumes: Events are one-clock pulses synchronous to aclk
// Notes: Pending ignores the global enable; the sequencer applies it
module iec_flags
  import iec_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  iec_flag_if.owner fi
);

  typedef struct packed {
    logic tim_flag;
    logic ext_flag;
    logic [7:0] pf1;
    logic [7:0] pf2;
    logic pending;
    logic wake_req;
  } iec_flags_s;

  iec_flags_s s;
  iec_flags_s next_s;

  // ----------------------------------------
  // Flag update and gating
  // ----------------------------------------
  always_comb begin
    logic ctrl_hit;
    logic p_hit;
    ctrl_hit = 1'b0;
    p_hit = 1'b0;
    next_s = s;
    next_s.tim_flag = (fi.wr_ctrl ? fi.wdata[TIM_FLAG_BIT] : s.tim_flag) | fi.ev_tmr0;
    next_s.ext_flag = (fi.wr_ctrl ? fi.wdata[EXT_FLAG_BIT] : s.ext_flag) | fi.ev_int;
    next_s.pf1 = (fi.wr_pf1 ? fi.wdata : s.pf1) | fi.ev_pf1;
    next_s.pf2 = (fi.wr_pf2 ? fi.wdata : s.pf2) | fi.ev_pf2;
    ctrl_hit = (next_s.tim_flag & fi.ctrl_en[TIM_EN_BIT]) | (next_s.ext_flag & fi.ctrl_en[EXT_EN_BIT])
      | (fi.ioc_any & fi.ctrl_en[CHG_EN_BIT]);
    p_hit = fi.ctrl_en[GRP_EN_BIT] & (|((next_s.pf1 & fi.pe1) | (next_s.pf2 & fi.pe2)));
    next_s.pending = ctrl_hit | p_hit;
    next_s.wake_req = fi.sleeping & ((ctrl_hit & fi.wake_en[WAKE_CTRL_BIT])
      | (fi.ctrl_en[GRP_EN_BIT] & fi.wake_en[WAKE_P1_BIT] & (|(next_s.pf1 & fi.pe1)))
      | (fi.ctrl_en[GRP_EN_BIT] & fi.wake_en[WAKE_P2_BIT] & (|(next_s.pf2 & fi.pe2))));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fi.ctrl_flags = {s.tim_flag, s.ext_flag, fi.ioc_any};
  assign fi.pf1 = s.pf1;
  assign fi.pf2 = s.pf2;
  assign fi.pending = s.pending;
  assign fi.wake_req = s.wake_req;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_flag_sets;
    @(posedge aclk) disable iff (!aresetn) fi.ev_tmr0 |=> s.tim_flag;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("timer flag not set by its event");

  property p_set_beats_clear;
    @(posedge aclk) disable iff (!aresetn) (fi.wr_pf1 && fi.ev_pf1[0] && !fi.wdata[0]) |=> s.pf1[0];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("flag lost to clear");

endmodule : iec_flags

/* design/iec_top.sv */
// Purpose: Interrupt gating, entry and return sequencing with AXI4-Lite registers
// Assumes: Core events and strobes are synchronous one-clock pulses
// Notes: One instruction cycle is TCY_CLKS clocks
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
module iec_top
  import iec_pkg::*;
#(
  parameter int CTX_W = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ev_tmr0,
  input wire logic ev_int,
  input wire logic [7:0] ev_pf1,
  input wire logic [7:0] ev_pf2,
  input wire logic ioc_any,
  input wire logic [PC_W-1:0] core_pc,
  input wire logic [CTX_W-1:0] core_ctx,
  input wire logic core_sleeping,
  input wire logic core_instr_done,
  input wire logic core_return,
  output logic core_flush,
  output logic core_push,
  output logic [PC_W-1:0] core_push_pc,
  output logic core_pc_load,
  output logic [PC_W-1:0] core_pc_value,
  output logic core_pop,
  output logic core_ctx_restore,
  output logic [CTX_W-1:0] core_ctx_value,
  output logic core_wake,
  output logic irq
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] ctrl_en;
    logic [7:0] pe1;
    logic [7:0] pe2;
    logic [2:0] wake_en;
    logic [EV_W-1:0] ists;
    logic [EV_W-1:0] imsk;
    logic irq;
    iec_seq_e st;
    logic [CNT_W-1:0] cnt;
    logic flush;
    logic push;
    logic [PC_W-1:0] push_pc;
    logic pc_load;
    logic [PC_W-1:0] pc_value;
    logic pop;
    logic ctx_restore;
    logic [CTX_W-1:0] shadow;
    logic [CTX_W-1:0] ctx_value;
    logic wake;
  } iec_top_s;

  localparam logic [CNT_W-1:0] TCY_LAST = CNT_W'(TCY_CLKS - 1);

  iec_top_s s;
  iec_top_s next_s;
  iec_flag_if fi ();

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFF_CTRL) || (a == OFF_PF1) || (a == OFF_PF2) || (a == OFF_PE1) || (a == OFF_PE2)
      || (a == OFF_WAKE) || (a == OFF_SEQ) || (a == OFF_ISTS) || (a == OFF_IMSK);
  endfunction : mapped

  function automatic logic wr_hit(input iec_top_s c, input logic go, input logic [ADDR_W-1:0] off);
    wr_hit = go && c.w_lane0 && (c.aw_addr == off);
  endfunction : wr_hit

  iec_flags u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .fi(fi.owner)
  );

  logic wr_go;
  assign wr_go = s.aw_got && s.w_got && !s.bvalid;

  // ----------------------------------------
  // Flag bank connection
  // ----------------------------------------
  assign fi.wdata = s.w_data;
  assign fi.wr_ctrl = wr_hit(s, wr_go, OFF_CTRL);
  assign fi.wr_pf1 = wr_hit(s, wr_go, OFF_PF1);
  assign fi.wr_pf2 = wr_hit(s, wr_go, OFF_PF2);
  assign fi.ev_tmr0 = ev_tmr0;
  assign fi.ev_int = ev_int;
  assign fi.ev_pf1 = ev_pf1;
  assign fi.ev_pf2 = ev_pf2;
  assign fi.ioc_any = ioc_any;
  assign fi.ctrl_en = s.ctrl_en;
  assign fi.pe1 = s.pe1;
  assign fi.pe2 = s.pe2;
  assign fi.wake_en = s.wake_en;
  assign fi.sleeping = core_sleeping;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [EV_W-1:0] ev;
    logic [7:0] rd;
    logic [7:0] ctrl_rd;
    next_s = s;
    ev = '0;
    rd = '0;
    ctrl_rd = {s.ctrl_en[GLB_EN_BIT:CHG_EN_BIT], fi.ctrl_flags};
    next_s.flush = 1'b0;
    next_s.push = 1'b0;
    next_s.pc_load = 1'b0;
    next_s.pop = 1'b0;
    next_s.ctx_restore = 1'b0;
    next_s.wake = 1'b0;
    // Write channel handling
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_got = 1'b1;
      next_s.w_data = s_axi_wdata[7:0];
      next_s.w_lane0 = s_axi_wstrb[0];
    end
    if (wr_go) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      if (wr_hit(s, wr_go, OFF_CTRL)) begin
        next_s.ctrl_en[GLB_EN_BIT:CHG_EN_BIT] = s.w_data[GLB_EN_BIT:CHG_EN_BIT];
      end
      if (wr_hit(s, wr_go, OFF_PE1)) begin
        next_s.pe1 = s.w_data;
      end
      if (wr_hit(s, wr_go, OFF_PE2)) begin
        next_s.pe2 = s.w_data;
      end
      if (wr_hit(s, wr_go, OFF_WAKE)) begin
        next_s.wake_en = s.w_data[EV_W-1:0];
      end
      if (wr_hit(s, wr_go, OFF_IMSK)) begin
        next_s.imsk = s.w_data[EV_W-1:0];
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    // Read channel handling
    if (s.arready && s_axi_arvalid) begin
      case (s_axi_araddr)
        OFF_CTRL: rd = ctrl_rd;
        OFF_PF1: rd = fi.pf1;
        OFF_PF2: rd = fi.pf2;
        OFF_PE1: rd = s.pe1;
        OFF_PE2: rd = s.pe2;
        OFF_WAKE: rd = {5'h00, s.wake_en};
        OFF_SEQ: rd = {4'h0, fi.pending, s.st};
        OFF_ISTS: rd = {5'h00, s.ists};
        OFF_IMSK: rd = {5'h00, s.imsk};
        default: rd = 8'h00;
      endcase
      next_s.rdata = {24'h000000, rd};
      next_s.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_s.rvalid = 1'b1;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = !next_s.rvalid;
    // Entry, wake and return sequencer
    next_s.cnt = (s.cnt == TCY_LAST) ? '0 : s.cnt + CNT_W'(1);
    case (s.st)
      IEC_IDLE: begin
        next_s.cnt = '0;
        if (core_return) begin
          next_s.pop = 1'b1;
          next_s.ctx_restore = 1'b1;
          next_s.ctx_value = s.shadow;
          next_s.ctrl_en[GLB_EN_BIT] = 1'b1;
          ev[EV_RETURN] = 1'b1;
        end else if (core_sleeping && fi.wake_req) begin
          next_s.wake = 1'b1;
          next_s.st = IEC_WAKE;
          ev[EV_WAKE] = 1'b1;
        end else if (!core_sleeping && s.ctrl_en[GLB_EN_BIT] && fi.pending) begin
          next_s.flush = 1'b1;
          next_s.ctrl_en[GLB_EN_BIT] = 1'b0;
          next_s.st = IEC_FLUSH;
          ev[EV_ENTRY] = 1'b1;
        end
      end
      IEC_WAKE: begin
        next_s.cnt = '0;
        if (core_instr_done) begin
          if (s.ctrl_en[GLB_EN_BIT] && fi.pending) begin
            next_s.flush = 1'b1;
            next_s.ctrl_en[GLB_EN_BIT] = 1'b0;
            next_s.st = IEC_FLUSH;
            ev[EV_ENTRY] = 1'b1;
          end else begin
            next_s.st = IEC_IDLE;
          end
        end
      end
      IEC_FLUSH: begin
        next_s.ctrl_en[GLB_EN_BIT] = 1'b0;
        if (s.cnt == TCY_LAST) begin
          next_s.push = 1'b1;
          next_s.push_pc = core_pc;
          next_s.shadow = core_ctx;
          next_s.st = IEC_PUSH;
        end
      end
      IEC_PUSH: begin
        if (s.cnt == TCY_LAST) begin
          next_s.pc_load = 1'b1;
          next_s.pc_value = VECTOR_ADDR;
          next_s.st = IEC_JUMP;
        end
      end
      IEC_JUMP: begin
        if (s.cnt == TCY_LAST) begin
          next_s.st = IEC_IDLE;
        end
      end
      default: begin
        next_s.st = IEC_IDLE;
      end
    endcase
    // Event status, write one to clear, set wins
    next_s.ists = s.ists;
    if (wr_hit(s, wr_go, OFF_ISTS)) begin
      next_s.ists = s.ists & ~s.w_data[EV_W-1:0];
    end
    next_s.ists = next_s.ists | ev;
    next_s.irq = |(next_s.ists & next_s.imsk);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl_en <= CTRL_RST;
      s.pe1 <= PE1_RST;
      s.pe2 <= PE2_RST;
      s.st <= IEC_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign core_flush = s.flush;
  assign core_push = s.push;
  assign core_push_pc = s.push_pc;
  assign core_pc_load = s.pc_load;
  assign core_pc_value = s.pc_value;
  assign core_pop = s.pop;
  assign core_ctx_restore = s.ctx_restore;
  assign core_ctx_value = s.ctx_value;
  assign core_wake = s.wake;
  assign irq = s.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  localparam int A_TCY = 4;

  property p_reset_off;
    @(posedge aclk) disable iff (!aresetn) $rose(aresetn) |-> !s.ctrl_en[GLB_EN_BIT] && !s.ctrl_en[GRP_EN_BIT];
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("enables not cleared by reset");

  property p_gated;
    @(posedge aclk) disable iff (!aresetn) $rose(s.flush) |-> $past(s.ctrl_en[GLB_EN_BIT]) && $past(fi.pending);
  endproperty
  a_gated: assert property (p_gated) else $error("entry without enables");

  sequence s_push_step;
    ##A_TCY s.push && s.push_pc == $past(core_pc);
  endsequence
  sequence s_jump_step;
    ##A_TCY s.pc_load && s.pc_value == VECTOR_ADDR;
  endsequence
  property p_entry;
    @(posedge aclk) disable iff (!aresetn) s.flush |-> !s.ctrl_en[GLB_EN_BIT] ##0 s_push_step ##0 s_jump_step;
  endproperty
  a_entry: assert property (p_entry) else $error("entry sequence out of order");

  property p_no_nest;
    @(posedge aclk) disable iff (!aresetn) !s.ctrl_en[GLB_EN_BIT] |=> !s.flush;
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("vectored with global enable clear");

  property p_return;
    @(posedge aclk) disable iff (!aresetn) (s.st == IEC_IDLE && core_return)
      |=> s.pop && s.ctx_restore && s.ctrl_en[GLB_EN_BIT] && s.ctx_value == $past(s.shadow);
  endproperty
  a_return: assert property (p_return) else $error("return did not restore");

  property p_serve_pending;
    @(posedge aclk) disable iff (!aresetn)
      (s.st == IEC_IDLE && s.ctrl_en[GLB_EN_BIT] && fi.pending && !core_sleeping && !core_return) |=> s.flush;
  endproperty
  a_serve_pending: assert property (p_serve_pending) else $error("pending request not served");

  property p_wake;
    @(posedge aclk) disable iff (!aresetn)
      (s.st == IEC_IDLE && core_sleeping && fi.wake_req && !core_return) |=> s.wake ##1 s.st == IEC_WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not raised");

  property p_wake_first;
    @(posedge aclk) disable iff (!aresetn) (s.st == IEC_WAKE && !core_instr_done) |=> !s.flush;
  endproperty
  a_wake_first: assert property (p_wake_first) else $error("vectored before post-sleep instruction");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn) s.irq == (|(s.ists & s.imsk));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output disagrees with status");

endmodule : iec_top

/* tb/iec_core_model.sv */
// Purpose: Behavioural processor core facing the interrupt block
// Assumes: One clock; every strobe lasts one cycle
// Notes: Return and sleep are requested by the bench
module iec_core_model
  import iec_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ret_req,
  input wire logic sleep_req,
  input wire logic core_flush,
  input wire logic core_push,
  input wire logic [PC_W-1:0] core_push_pc,
  input wire logic core_pc_load,
  input wire logic [PC_W-1:0] core_pc_value,
  input wire logic core_pop,
  input wire logic core_wake,
  output logic [PC_W-1:0] core_pc,
  output logic core_sleeping,
  output logic core_instr_done,
  output logic core_return
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PC_W-1:0] stk;
  logic busy;
  logic [1:0] wk;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_pc <= 13'h0100;
      stk <= 13'h0000;
      busy <= 1'h0;
      wk <= 2'h0;
      core_sleeping <= 1'h0;
      core_instr_done <= 1'h0;
      core_return <= 1'h0;
    end else begin
      core_return <= ret_req;
      // Instruction after sleep completes a few cycles after waking
      core_instr_done <= (wk == 2'h1);
      if (wk != 2'h0)
        wk <= wk - 2'h1;
      if (sleep_req)
        core_sleeping <= 1'h1;
      if (core_wake) begin
        core_sleeping <= 1'h0;
        wk <= 2'h3;
      end
      // Program counter freezes from flush until the vector load
      if (core_flush)
        busy <= 1'h1;
      if (core_push)
        stk <= core_push_pc;
      if (core_pc_load) begin
        core_pc <= core_pc_value;
        busy <= 1'h0;
      end else if (core_pop)
        core_pc <= stk;
      else if (!busy && !core_sleeping)
        core_pc <= core_pc + 13'h0001;
    end
  end
endmodule : iec_core_model

/* tb/interrupt_entry_control_bench.sv */
// Purpose: Self-checking bench of the interrupt entry block
// Assumes: 50 MHz clock, core model on the far side
// Notes: Random source bits from a fixed seed
module interrupt_entry_control_bench;
  import iec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CW = 40;
  logic aclk, aresetn, awv, awr, wv, wrd, bv, brd, arv, ard, rv, rrd;
  logic [ADDR_W-1:0] awa, ara;
  logic [31:0] wd, rdat, rd;
  logic [1:0] bresp, rresp, rs;
  logic e_t, e_i, ret_req, slp_req, slp, idone, ret, fl, push, pcl, pop, wake, irq, ioc, crs;
  logic [7:0] e_p1, e_p2;
  logic [PC_W-1:0] pc, ppc, pcv, spc;
  logic [CW-1:0] ctx, ctxv;
  int error_cnt, num_checks, n, b, lat;

  always #10 aclk = ~aclk;

  iec_top #(.CTX_W(CW)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(ard), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd),
    .ev_tmr0(e_t), .ev_int(e_i), .ev_pf1(e_p1), .ev_pf2(e_p2), .ioc_any(ioc), .core_pc(pc), .core_ctx(ctx),
    .core_sleeping(slp), .core_instr_done(idone), .core_return(ret), .core_flush(fl), .core_push(push),
    .core_push_pc(ppc), .core_pc_load(pcl), .core_pc_value(pcv), .core_pop(pop), .core_ctx_restore(crs),
    .core_ctx_value(ctxv), .core_wake(wake), .irq(irq));

  iec_core_model core (.aclk(aclk), .aresetn(aresetn), .ret_req(ret_req), .sleep_req(slp_req),
    .core_flush(fl), .core_push(push), .core_push_pc(ppc), .core_pc_load(pcl), .core_pc_value(pcv),
    .core_pop(pop), .core_wake(wake), .core_pc(pc), .core_sleeping(slp), .core_instr_done(idone),
    .core_return(ret));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
    bit ad;
    bit dd;
    ad = 1'h0;
    dd = 1'h0;
    awa <= a;
    wd <= {24'h000000, d};
    awv <= 1'h1;
    wv <= 1'h1;
    brd <= 1'h1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awv && awr === 1'h1) begin
        ad = 1'h1;
        awv <= 1'h0;
      end
      if (wv && wrd === 1'h1) begin
        dd = 1'h1;
        wv <= 1'h0;
      end
    end
    while (bv !== 1'h1) @(posedge aclk);
    r = bresp;
    brd <= 1'h0;
    @(posedge aclk);
  endtask : wr

  task automatic rdr(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'h1;
    rrd <= 1'h1;
    do @(posedge aclk); while (ard !== 1'h1);
    arv <= 1'h0;
    while (rv !== 1'h1) @(posedge aclk);
    d = rdat;
    r = rresp;
    rrd <= 1'h0;
    @(posedge aclk);
  endtask : rdr

  task automatic w(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    wr(a, d, rs);
    chk("bresp", 64'(RESP_OKAY), 64'(rs));
  endtask : w

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
    rdr(a, rd, rs);
    chk(nm, 64'(e), 64'(rd));
  endtask : rchk

  task automatic ev(input int k, input logic [7:0] m);
    case (k)
      0: e_t <= 1'h1;
      1: e_i <= 1'h1;
      2: e_p1 <= m;
      3: e_p2 <= m;
      4: slp_req <= 1'h1;
      default: ret_req <= 1'h1;
    endcase
    @(posedge aclk);
    e_t <= 1'h0;
    e_i <= 1'h0;
    e_p1 <= 8'h00;
    e_p2 <= 8'h00;
    slp_req <= 1'h0;
    ret_req <= 1'h0;
    @(posedge aclk);
  endtask : ev

  task automatic wfor(input int s, input int lim, output int c);
    c = -1;
    for (int i = 1; i <= lim && c < 0; i++) begin
      @(posedge aclk);
      if ((s == 0 && fl === 1'h1) || (s == 1 && pcl === 1'h1) || (s == 2 && wake === 1'h1) ||
          (s == 3 && pop === 1'h1) || (s == 4 && push === 1'h1))
        c = i;
    end
  endtask : wfor

  task automatic nofl();
    wfor(0, 24, n);
    chk("no entry", 64'h1, 64'(n < 0));
  endtask : nofl

  task automatic enter();
    wfor(0, 40, n);
    lat = n;
    chk("flush", 64'h1, 64'(n > 0));
    wfor(4, 10, n);
    lat += n;
    chk("push pc", 64'(pc), 64'(ppc));
    spc = pc;
    wfor(1, 10, n);
    lat += n;
    chk("vector", 64'h4, 64'(pcv));
  endtask : enter

  task automatic leave(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    w(a, d);
    ev(5, 8'h00);
    wfor(3, 10, n);
    chk("shadow", 64'(ctx), 64'(ctxv));
    chk("restore", 64'h1, 64'(crs));
    @(posedge aclk);
    chk("return pc", 64'(spc), 64'(pc));
  endtask : leave

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {aclk, aresetn, awv, wv, brd, arv, rrd, e_t, e_i, ret_req, slp_req, ioc} = '0;
    {awa, ara, wd, e_p1, e_p2} = '0;
    void'($urandom(47478));
    ctx = CW'({$urandom(), $urandom()});
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    rchk(OFF_CTRL, 32'h0, "ctrl reset");
    rchk(OFF_PE1, 32'h4, "pe1 reset");
    rchk(OFF_PE2, 32'h0, "pe2 reset");
    rdr(6'h24, rd, rs);
    chk("unmapped read", 64'(RESP_SLVERR), 64'(rs));
    wr(6'h24, 8'hFF, rs);
    chk("unmapped write", 64'(RESP_SLVERR), 64'(rs));
    ioc <= 1'h1;
    rchk(OFF_CTRL, 32'h1, "change flag");
    ioc <= 1'h0;
    $display("test reset values done");
    b = $urandom_range(7, 0);
    ev(0, 8'h00);
    ev(1, 8'h00);
    ev(2, 8'h01 << b);
    rchk(OFF_CTRL, 32'h06, "ctrl flags");
    rchk(OFF_PF1, 32'h1 << b, "pf1 flag");
    nofl();
    w(OFF_CTRL, 8'h84);
    w(OFF_PF1, 8'h00);
    fork
      w(OFF_PF1, 8'h00);
      begin
        @(posedge aclk);
        e_p1 <= 8'h01;
        @(posedge aclk);
        e_p1 <= 8'h00;
      end
    join
    rchk(OFF_PF1, 32'h1, "set beats clear");
    w(OFF_PF1, 8'h00);
    nofl();
    $display("test flags done");
    w(OFF_CTRL, 8'hA4);
    enter();
    rchk(OFF_CTRL, 32'h24, "global cleared");
    w(OFF_CTRL, 8'h20);
    ev(0, 8'h00);
    rchk(OFF_CTRL, 32'h24, "flag in handler");
    nofl();
    leave(OFF_CTRL, 8'h20);
    rchk(OFF_CTRL, 32'hA0, "global restored");
    ev(0, 8'h00);
    enter();
    chk("latency", 64'h1, 64'(lat + 1 >= 2 * TCY_CLKS && lat + 1 <= 3 * TCY_CLKS));
    leave(OFF_CTRL, 8'h20);
    $display("test entry and return done");
    b = $urandom_range(7, 0);
    w(OFF_PE2, 8'h01 << b);
    w(OFF_CTRL, 8'h80);
    ev(3, 8'h01 << b);
    nofl();
    w(OFF_CTRL, 8'hC0);
    enter();
    leave(OFF_PF2, 8'h00);
    w(OFF_CTRL, 8'h00);
    w(OFF_PE2, 8'h00);
    $display("test group enable done");
    rchk(OFF_ISTS, 32'h3, "event status");
    chk("irq masked", 64'h0, 64'(irq));
    w(OFF_IMSK, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq raised", 64'h1, 64'(irq));
    w(OFF_ISTS, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 64'h0, 64'(irq));
    $display("test status irq done");
    w(OFF_CTRL, 8'h10);
    w(OFF_WAKE, 8'h01);
    ev(4, 8'h00);
    ev(1, 8'h00);
    wfor(2, 20, n);
    chk("wake", 64'h1, 64'(n > 0));
    nofl();
    w(OFF_CTRL, 8'h90);
    ev(4, 8'h00);
    ev(1, 8'h00);
    wfor(2, 20, n);
    chk("wake enabled", 64'h1, 64'(n > 0));
    enter();
    leave(OFF_CTRL, 8'h10);
    $display("test sleep wake done");
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    rchk(OFF_CTRL, 32'h0, "ctrl second reset");
    chk("irq second reset", 64'h0, 64'(irq));
    $display("test second reset done");
    final_report();
  end

  initial begin
    #200000;
    error_cnt++;
    $display("watchdog expired");
    final_report();
  end
endmodule : interrupt_entry_control_bench
